//--- common/rgc_pkg.sv
// Constants and types for the respiration and GPIO configuration registers
package rgc_pkg;

	// Register indices; byte address is index times four
	localparam logic [5:0] RGC_IDX_RESP_ONE = 6'h09;
	localparam logic [5:0] RGC_IDX_RESP_TWO = 6'h0a;
	localparam logic [5:0] RGC_IDX_GPIO = 6'h0b;
	localparam int RGC_ADDR_W = 8;
	localparam int RGC_DATA_W = 32;
	localparam int RGC_REG_W = 8;
	localparam int RGC_PINS = 2;

	// Values after reset
	localparam logic [7:0] RGC_RST_RESP_ONE = 8'h02;
	localparam logic [7:0] RGC_RST_RESP_TWO = 8'h03;
	localparam logic [7:0] RGC_RST_GPIO = 8'h0c;

	// First respiration register fields
	localparam int RGC_R1_DEMOD_EN = 7;
	localparam int RGC_R1_MOD_EN = 6;
	localparam int RGC_R1_PHASE_HI = 5;
	localparam int RGC_R1_PHASE_LO = 2;
	localparam int RGC_R1_FIXED_ONE = 1;
	localparam int RGC_R1_SRC_MODE = 0;

	// Second respiration register fields
	localparam int RGC_R2_CAL_EN = 7;
	localparam int RGC_R2_ZERO_HI = 6;
	localparam int RGC_R2_ZERO_LO = 3;
	localparam int RGC_R2_FREQ = 2;
	localparam int RGC_R2_REF_INT = 1;
	localparam int RGC_R2_FIXED_ONE = 0;

	// GPIO register fields
	localparam int RGC_G_DIR_HI = 3;
	localparam int RGC_G_DIR_LO = 2;
	localparam int RGC_G_DATA_HI = 1;
	localparam int RGC_G_DATA_LO = 0;

	// Phase steps in hundredths of a degree
	localparam logic [15:0] RGC_STEP_32K_CDEG = 16'h0465;
	localparam logic [15:0] RGC_STEP_64K_CDEG = 16'h08ca;

	// Bus answer state, Gray coded
	typedef enum logic [1:0] {
		RGC_IDLE = 2'b00,
		RGC_ANSWER = 2'b01
	} rgc_bus_state_t;

endpackage

//--- rtl/rgc_gpio_pin.sv
// One general-purpose pin with direction, output latch and readback
`timescale 1ns/1ps
module rgc_gpio_pin (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic dir_input_i,
	input wire logic wr_en_i,
	input wire logic wr_value_i,
	input wire logic taken_i,
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o,
	output logic level_o
);

	logic out_r;
	logic out_nxt;
	wire load_ok = wr_en_i & ~dir_input_i & ~taken_i;

	// Writes to an input pin are dropped, so the latch never changes then
	assign out_nxt = load_ok ? wr_value_i : out_r;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
		end
	end

	assign pin_o = out_r;
	// Driven only when set as output and not claimed by respiration
	assign pin_oe_o = ~dir_input_i & ~taken_i;
	// Readback is the live pin, forced low while claimed by respiration, never the latch
	assign level_o = pin_i & ~taken_i;

endmodule

//--- rtl/rgc_config_regs.sv
// Respiration, calibration and GPIO configuration register bank on Avalon-MM
// What this block does
// - Phase step 11.25 or 22.5 degrees by rate
// - Mode bit picks internal or external clock
// - Bit 7 enables offset calibration, reset off
// - Frequency bit picks 32 or 64 kHz
// - Reference bit picks external or mid-supply
// - Direction bits: zero output, one input
// - Data read returns live pin levels, zero while the pins are claimed
// - Output pin data write sets level, dropped while the pins are claimed
// - Input pin data write does nothing
// - External-clock respiration mode takes over the pins while modulation or demodulation is enabled
// - First respiration register at index 09h
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module rgc_config_regs (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic breath_demod_enable_o,
	output logic breath_mod_enable_o,
	output logic [3:0] demod_phase_code_o,
	output logic [15:0] demod_phase_cdeg_o,
	output logic breath_clock_source_mode_o,
	output logic breath_clock_rate_64k_o,
	output logic offset_cal_enable_o,
	output logic drive_ref_internal_select_o,
	input wire logic [1:0] gpio_pin_i,
	output logic [1:0] gpio_pin_o,
	output logic [1:0] gpio_pin_oe_o,
	output logic gpio_taken_o,
	output logic breath_ext_clk_o
);

	// Register state
	logic [7:0] resp_one_r;
	logic [7:0] resp_one_nxt;
	logic [7:0] resp_two_r;
	logic [7:0] resp_two_nxt;
	logic [1:0] pin_dir_r;
	logic [1:0] pin_dir_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [15:0] phase_cdeg_r;
	logic [15:0] phase_cdeg_nxt;
	logic ext_clk_r;
	logic ext_clk_nxt;
	rgc_pkg::rgc_bus_state_t state_r;
	rgc_pkg::rgc_bus_state_t state_nxt;

	// Bus decode
	wire [5:0] reg_index = avs_address_i[7:2];
	wire aligned = (avs_address_i[1:0] == 2'b00);
	wire request = avs_read_i | avs_write_i;
	wire in_idle = (state_r == rgc_pkg::RGC_IDLE);
	wire in_answer = (state_r == rgc_pkg::RGC_ANSWER);
	wire low_lane = avs_byteenable_i[0];
	wire [7:0] wbyte = avs_writedata_i[7:0];

	wire hit_one = aligned & (reg_index == rgc_pkg::RGC_IDX_RESP_ONE);
	wire hit_two = aligned & (reg_index == rgc_pkg::RGC_IDX_RESP_TWO);
	wire hit_gpio = aligned & (reg_index == rgc_pkg::RGC_IDX_GPIO);

	// Writes commit at the edge where waitrequest is low
	wire commit = in_answer & avs_write_i & low_lane;
	logic wr_one;
	logic wr_two;
	logic wr_gpio;

	// One register at most is written per transfer
	always_comb begin
		wr_one = 1'b0;
		wr_two = 1'b0;
		wr_gpio = 1'b0;
		if (commit & hit_one) begin
			wr_one = 1'b1;
		end else if (commit & hit_two) begin
			wr_two = 1'b1;
		end else if (commit & hit_gpio) begin
			wr_gpio = 1'b1;
		end
	end

	// One wait state per transfer keeps read data registered
	assign avs_waitrequest_o = request & in_idle;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			rgc_pkg::RGC_IDLE: begin
				if (request) begin
					state_nxt = rgc_pkg::RGC_ANSWER;
				end
			end
			rgc_pkg::RGC_ANSWER: begin
				state_nxt = rgc_pkg::RGC_IDLE;
			end
			default: begin
				state_nxt = rgc_pkg::RGC_IDLE;
			end
		endcase
	end

	// Field views of the first respiration register
	wire demod_en = resp_one_r[rgc_pkg::RGC_R1_DEMOD_EN];
	wire mod_en = resp_one_r[rgc_pkg::RGC_R1_MOD_EN];
	wire [3:0] phase_code = resp_one_r[rgc_pkg::RGC_R1_PHASE_HI:rgc_pkg::RGC_R1_PHASE_LO];
	wire src_external = resp_one_r[rgc_pkg::RGC_R1_SRC_MODE];

	// Field views of the second respiration register
	wire cal_en = resp_two_r[rgc_pkg::RGC_R2_CAL_EN];
	wire freq_64k = resp_two_r[rgc_pkg::RGC_R2_FREQ];
	wire ref_internal = resp_two_r[rgc_pkg::RGC_R2_REF_INT];

	// Reserved bits are forced to their fixed values on every write, so they read back fixed
	always_comb begin
		resp_one_nxt = resp_one_r;
		if (wr_one) begin
			resp_one_nxt = wbyte;
			resp_one_nxt[rgc_pkg::RGC_R1_FIXED_ONE] = 1'b1;
		end
	end

	always_comb begin
		resp_two_nxt = resp_two_r;
		if (wr_two) begin
			resp_two_nxt = wbyte;
			resp_two_nxt[rgc_pkg::RGC_R2_ZERO_HI:rgc_pkg::RGC_R2_ZERO_LO] = 4'h0;
			resp_two_nxt[rgc_pkg::RGC_R2_FIXED_ONE] = 1'b1;
		end
	end

	assign pin_dir_nxt = wr_gpio ? wbyte[rgc_pkg::RGC_G_DIR_HI:rgc_pkg::RGC_G_DIR_LO] : pin_dir_r;

	// The external-clock mode with the respiration path running claims both pins
	wire taken = src_external & (mod_en | demod_en);

	// Phase angle: top code bit is ignored at the faster rate
	// A table instead of a multiplier keeps the angle path small and exact
	logic [15:0] angle_32k;
	logic [15:0] angle_64k;

	always_comb begin
		angle_32k = 16'h0000;
		case (phase_code)
			4'h0: begin
				angle_32k = 16'h0000;
			end
			4'h1: begin
				angle_32k = 16'h0465;
			end
			4'h2: begin
				angle_32k = 16'h08ca;
			end
			4'h3: begin
				angle_32k = 16'h0d2f;
			end
			4'h4: begin
				angle_32k = 16'h1194;
			end
			4'h5: begin
				angle_32k = 16'h15f9;
			end
			4'h6: begin
				angle_32k = 16'h1a5e;
			end
			4'h7: begin
				angle_32k = 16'h1ec3;
			end
			4'h8: begin
				angle_32k = 16'h2328;
			end
			4'h9: begin
				angle_32k = 16'h278d;
			end
			4'ha: begin
				angle_32k = 16'h2bf2;
			end
			4'hb: begin
				angle_32k = 16'h3057;
			end
			4'hc: begin
				angle_32k = 16'h34bc;
			end
			4'hd: begin
				angle_32k = 16'h3921;
			end
			4'he: begin
				angle_32k = 16'h3d86;
			end
			4'hf: begin
				angle_32k = 16'h41eb;
			end
			default: begin
				angle_32k = 16'h0000;
			end
		endcase
	end

	// Only the low three code bits select an angle at the faster rate
	always_comb begin
		angle_64k = 16'h0000;
		case (phase_code[2:0])
			3'h0: begin
				angle_64k = 16'h0000;
			end
			3'h1: begin
				angle_64k = 16'h08ca;
			end
			3'h2: begin
				angle_64k = 16'h1194;
			end
			3'h3: begin
				angle_64k = 16'h1a5e;
			end
			3'h4: begin
				angle_64k = 16'h2328;
			end
			3'h5: begin
				angle_64k = 16'h2bf2;
			end
			3'h6: begin
				angle_64k = 16'h34bc;
			end
			3'h7: begin
				angle_64k = 16'h3d86;
			end
			default: begin
				angle_64k = 16'h0000;
			end
		endcase
	end

	assign phase_cdeg_nxt = freq_64k ? angle_64k : angle_32k;

	// Pin cells
	logic [1:0] pin_level;

	rgc_gpio_pin u_pin_one (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.dir_input_i(pin_dir_r[0]),
		.wr_en_i(wr_gpio),
		.wr_value_i(wbyte[rgc_pkg::RGC_G_DATA_LO]),
		.taken_i(taken),
		.pin_i(gpio_pin_i[0]),
		.pin_o(gpio_pin_o[0]),
		.pin_oe_o(gpio_pin_oe_o[0]),
		.level_o(pin_level[0])
	);

	rgc_gpio_pin u_pin_two (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.dir_input_i(pin_dir_r[1]),
		.wr_en_i(wr_gpio),
		.wr_value_i(wbyte[rgc_pkg::RGC_G_DATA_HI]),
		.taken_i(taken),
		.pin_i(gpio_pin_i[1]),
		.pin_o(gpio_pin_o[1]),
		.pin_oe_o(gpio_pin_oe_o[1]),
		.level_o(pin_level[1])
	);

	// Read views of each register
	wire [7:0] view_one = resp_one_r;
	wire [7:0] view_two = resp_two_r;
	wire [7:0] view_gpio = {4'h0, pin_dir_r, pin_level};

	// Read data is captured in the wait cycle and held for the answer edge
	// Unmapped and misaligned reads fall through to zero
	logic [7:0] read_byte;

	always_comb begin
		read_byte = 8'h00;
		if (hit_one) begin
			read_byte = view_one;
		end else if (hit_two) begin
			read_byte = view_two;
		end else if (hit_gpio) begin
			read_byte = view_gpio;
		end
	end

	always_comb begin
		rdata_nxt = rdata_r;
		if (in_idle & avs_read_i) begin
			rdata_nxt = {24'h000000, read_byte};
		end
	end

	// External respiration clock is sampled from the first pin while claimed
	assign ext_clk_nxt = taken & gpio_pin_i[0];

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= rgc_pkg::RGC_IDLE;
			rdata_r <= 32'h00000000;
		end else begin
			state_r <= state_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			resp_one_r <= rgc_pkg::RGC_RST_RESP_ONE;
			resp_two_r <= rgc_pkg::RGC_RST_RESP_TWO;
		end else begin
			resp_one_r <= resp_one_nxt;
			resp_two_r <= resp_two_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_dir_r <= rgc_pkg::RGC_RST_GPIO[rgc_pkg::RGC_G_DIR_HI:rgc_pkg::RGC_G_DIR_LO];
			phase_cdeg_r <= 16'h0000;
			ext_clk_r <= 1'b0;
		end else begin
			pin_dir_r <= pin_dir_nxt;
			phase_cdeg_r <= phase_cdeg_nxt;
			ext_clk_r <= ext_clk_nxt;
		end
	end

	// Outputs to the analog side come straight from the registers
	assign avs_readdata_o = rdata_r;
	assign breath_demod_enable_o = demod_en;
	assign breath_mod_enable_o = mod_en;
	assign demod_phase_code_o = phase_code;
	assign demod_phase_cdeg_o = phase_cdeg_r;
	assign breath_clock_source_mode_o = src_external;
	// Rate follows the bit in both modes; the host is trusted for plain variants
	assign breath_clock_rate_64k_o = freq_64k;
	assign offset_cal_enable_o = cal_en;
	assign drive_ref_internal_select_o = ref_internal;
	assign gpio_taken_o = taken;
	assign breath_ext_clk_o = ext_clk_r;

endmodule

//--- verification/rgc_config_regs_props.sv
// Port assertions for the respiration and GPIO register bank
`timescale 1ns/1ps
module rgc_config_regs_props (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic breath_demod_enable_o,
	input wire logic breath_mod_enable_o,
	input wire logic [3:0] demod_phase_code_o,
	input wire logic [15:0] demod_phase_cdeg_o,
	input wire logic breath_clock_source_mode_o,
	input wire logic breath_clock_rate_64k_o,
	input wire logic [1:0] gpio_pin_i,
	input wire logic [1:0] gpio_pin_o,
	input wire logic [1:0] gpio_pin_oe_o,
	input wire logic gpio_taken_o,
	input wire logic breath_ext_clk_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	wire req = avs_read_i | avs_write_i;
	wire done = avs_write_i & !avs_waitrequest_o;
	phase_map_a: assert property (
		##1 demod_phase_cdeg_o == ($past(breath_clock_rate_64k_o) ?
		16'($past(demod_phase_code_o) & 4'h7) * 16'h08ca : 16'($past(demod_phase_code_o)) * 16'h0465))
		else $error("phase angle wrong");
	taken_def_a: assert property (gpio_taken_o ==
		(breath_clock_source_mode_o & (breath_mod_enable_o | breath_demod_enable_o)))
		else $error("pin claim wrong");
	oe_taken_a: assert property (gpio_taken_o |-> gpio_pin_oe_o == 2'b00)
		else $error("pin driven while claimed");
	ext_clk_a: assert property (##1 breath_ext_clk_o ==
		($past(gpio_taken_o) & $past(gpio_pin_i[0]))) else $error("ext clock wrong");
	wait_one_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("wait not one cycle");
	wait_first_a: assert property (req && !avs_waitrequest_o |=> !req || avs_waitrequest_o)
		else $error("no wait on next request");
	cfg_hold_a: assert property (!done |=> $stable({breath_clock_rate_64k_o,
		breath_clock_source_mode_o, demod_phase_code_o, gpio_pin_oe_o}))
		else $error("config changed without write");
	pin_hold_a: assert property (!done |=> $stable(gpio_pin_o))
		else $error("pin latch changed without write");
endmodule
bind rgc_config_regs rgc_config_regs_props u_props (.*);

//--- verification/rgc_config_regs_tb_top.sv
// Self-checking bench for the respiration and GPIO register bank
`timescale 1ns/1ps
module rgc_config_regs_tb_top;
	logic clk_sys_i = 0, resetn_i = 0, avs_read_i = 0, avs_write_i = 0;
	logic [7:0] avs_address_i = 8'h00;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0] avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o, breath_demod_enable_o, breath_mod_enable_o;
	logic breath_clock_source_mode_o, breath_clock_rate_64k_o, offset_cal_enable_o;
	logic drive_ref_internal_select_o, gpio_taken_o, breath_ext_clk_o;
	logic [3:0] demod_phase_code_o;
	logic [15:0] demod_phase_cdeg_o;
	logic [1:0] gpio_pin_i, gpio_pin_o, gpio_pin_oe_o, ext_lvl = 2'b10;
	logic [7:0] q;
	int failures = 0, n_compared = 0;
	// Wire level: driven value where enabled, outside level elsewhere
	assign gpio_pin_i = (gpio_pin_oe_o & gpio_pin_o) | (~gpio_pin_oe_o & ext_lvl);
	rgc_config_regs dut (.*);
	always #50 clk_sys_i = ~clk_sys_i;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results;
		if (failures == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Request held until waitrequest is seen low; #1 lets that edge's updates land
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, d};
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		q = avs_readdata_o[7:0];
		if (n == 50) begin
			failures++;
			results();
		end
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		bus(1'b0, a, 8'h00);
		chk(q, exp, what);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		chk(offset_cal_enable_o, 0, "cal reset");
		chk(drive_ref_internal_select_o, 1, "ref reset");
		chk(gpio_pin_oe_o, 0, "oe reset");
		rd(8'h24, 8'h02, "resp one");
		rd(8'h28, 8'h03, "resp two");
		rd(8'h2c, 8'h0e, "gpio reset");
		rd(8'h30, 8'h00, "unmapped");
		rd(8'h25, 8'h00, "misaligned");
		for (int r = 0; r < 2; r++) begin
			for (int c = 0; c < 16; c++) begin
				bus(1, 8'h28, {r[0], 4'h0, r[0], !r[0], 1'b1});
				bus(1, 8'h24, {2'b00, c[3:0], 1'b1, c[0]});
				repeat (2) @(posedge clk_sys_i);
				chk(demod_phase_cdeg_o, 16'(r ? (c % 8) * 2250 : c * 1125), "phase");
				chk(breath_clock_rate_64k_o, 16'(r), "rate");
				chk(demod_phase_code_o, 16'(c), "code");
				chk(breath_clock_source_mode_o, 16'(c % 2), "mode");
				chk(offset_cal_enable_o, 16'(r), "cal");
				chk(drive_ref_internal_select_o, 16'(1 - r), "ref");
			end
		end
		rd(8'h28, 8'h85, "resp two back");
		// First write still sees both pins as inputs, so its data is dropped
		bus(1, 8'h2c, 8'h07);
		chk(gpio_pin_o, 2'b00, "input write");
		bus(1, 8'h2c, 8'h07);
		chk(gpio_pin_oe_o, 2'b10, "oe");
		chk(gpio_pin_o, 2'b10, "drive");
		rd(8'h2c, 8'h06, "gpio live");
		bus(1, 8'h2c, 8'h04);
		rd(8'h2c, 8'h04, "gpio low");
		@(posedge clk_sys_i);
		ext_lvl <= 2'b01;
		bus(1, 8'h24, 8'h43);
		chk(gpio_taken_o, 1, "taken");
		chk(breath_mod_enable_o, 1, "mod en");
		chk(breath_demod_enable_o, 0, "demod en");
		chk(gpio_pin_oe_o, 0, "oe taken");
		rd(8'h2c, 8'h04, "gpio taken");
		chk(breath_ext_clk_o, 1, "ext clk");
		results();
	end
endmodule
